//--- rtl/mlcs_pkg.sv
// Package for the per-line modem control and status bank.
// Assumes a 100 MHz system clock and a plain address/strobe register port.
package mlcs_pkg;

	localparam int LINES  = 16;
	localparam int LINE_W = 4;
	localparam int ADDR_W = 18;
	localparam int DATA_W = 16;

	// Unit placement: first unit, slot stride, register offsets in the unit
	localparam logic [17:0] BASE_FIRST  = 18'h3FA00;
	localparam logic [17:0] SLOT_STRIDE = 18'h00020;
	localparam logic [17:0] OFF_CSR     = 18'h00010;
	localparam logic [17:0] OFF_LSR     = 18'h00012;

	// Scanner control/status word
	localparam int CSR_LINE_LSB = 0;
	localparam int CSR_BUSY     = 4;
	localparam int CSR_SCAN_EN  = 5;
	localparam int CSR_INT_EN   = 6;
	localparam int CSR_DONE     = 7;
	localparam int CSR_STEP     = 8;
	localparam int CSR_MAINT    = 9;
	localparam int CSR_CLR_MUX  = 10;
	localparam int CSR_FLUSH    = 11;
	localparam int CSR_FLAG_LSB = 12;

	// Line status word
	localparam int LSR_LINE_EN   = 0;
	localparam int LSR_TERM_RDY  = 1;
	localparam int LSR_TX_REQ    = 2;
	localparam int LSR_NS_AUX    = 3;
	localparam int LSR_STAT_LSB  = 4;

	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam logic [3:0] STAT_RESET = 4'h0;
	localparam logic [3:0] MAINT_STAT = 4'hF;

	// Vectors: first one in the floating region, then two words apart
	localparam logic [8:0] VECTOR_FIRST = 9'h0C0;
	localparam logic [8:0] VECTOR_STEP  = 9'h004;

	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int CLK_HZ        = 1000000000 / CLK_PERIOD_NS;
	localparam int BAUD_1200     = 1200;
	localparam int BAUD_2400     = 2400;
	localparam int BAUD_4800     = 4800;
	localparam int BAUD_9600     = 9600;

	typedef enum logic [1:0] {
		MLCS_IDLE  = 2'b00,
		MLCS_TEST  = 2'b01,
		MLCS_FLUSH = 2'b10
	} mlcs_scan_type;

	typedef enum logic [1:0] {
		MLCS_B1200 = 2'b00,
		MLCS_B2400 = 2'b01,
		MLCS_B4800 = 2'b10,
		MLCS_B9600 = 2'b11
	} mlcs_baud_type;

endpackage

//--- rtl/mlcs_bit_clock.sv
// Switch-selected internal bit clock for one group of four synchronous lines.
// Assumes rate switches are static or change only rarely.
`timescale 1ns/1ps
module mlcs_bit_clock #(
	parameter int HALF_1200 = 41666,
	parameter int HALF_2400 = 20833,
	parameter int HALF_4800 = 10416,
	parameter int HALF_9600 = 5208
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire mlcs_pkg::mlcs_baud_type rate_sel_i,
	output logic                       bit_clk_o
);
	import mlcs_pkg::*;

	logic [16:0] count;
	logic [16:0] next_count;
	logic        next_level;
	logic [16:0] half;

	function automatic logic [16:0] half_of(input mlcs_baud_type sel);
		case (sel)
			MLCS_B1200: half_of = 17'(HALF_1200);
			MLCS_B2400: half_of = 17'(HALF_2400);
			MLCS_B4800: half_of = 17'(HALF_4800);
			default:    half_of = 17'(HALF_9600);
		endcase
	endfunction

	assign half = half_of(rate_sel_i);

	// Compare with >= so a switch to a faster rate never runs the count away
	always_comb begin
		next_count = count + 17'h00001;
		next_level = bit_clk_o;
		if (count >= half - 17'h00001) begin
			next_count = 17'h00000;
			next_level = ~bit_clk_o;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			count     <= 17'h00000;
			bit_clk_o <= 1'b0;
		end else begin
			count     <= next_count;
			bit_clk_o <= next_level;
		end
	end

endmodule

//--- rtl/mlcs_modem_ctrl.sv
// Per-line modem control and status bank with line scanner and bit clocks.
// Assumes leads are synchronous to clk_i and a single-cycle strobe bus master.
// Operation
// - Line enable lets a line's four status leads be read and scanned.
// - Four control bits per line read/write, cleared by reset and all-line clear.
// - Terminal ready bit drives the lead switching the modem onto the channel.
// - Transmit request bit set drives the request-to-send lead.
// - On synchronous lines the shared bit drives new-sync high.
// - On asynchronous lines the shared bit drives secondary transmit to mark.
// - Status bit four shows data set ready on synchronous lines.
// - Status bit four shows secondary receive marking on asynchronous lines.
// - Status bit five shows the clear-to-send lead.
// - Status bit six shows the carrier detect lead.
// - Status bit seven shows ring of selected line when its enable is set.
// - Status bits four to seven read zero while line enable is clear.
// - Unit decodes at its slot base, one slot up if older unit present.
// - Three vectors, two data and one modem, from the floating region.
// - Internal bit clock per four-line group at four switch-selected rates.
// - Scan runs free or steps one line at a time; both supported.
// - Four-bit line field selects which line control and status refer to.
// - All-line clear bit, write-ones-only, clears every line's control bits.
`timescale 1ns/1ps
module mlcs_modem_ctrl #(
	parameter int         UNIT_SLOT   = 0,
	parameter bit         OLDER_UNIT  = 1'b0,
	parameter logic [8:0] VECTOR_BASE = mlcs_pkg::VECTOR_FIRST,
	parameter int         HALF_1200   = mlcs_pkg::CLK_HZ / (2 * mlcs_pkg::BAUD_1200),
	parameter int         HALF_2400   = mlcs_pkg::CLK_HZ / (2 * mlcs_pkg::BAUD_2400),
	parameter int         HALF_4800   = mlcs_pkg::CLK_HZ / (2 * mlcs_pkg::BAUD_4800),
	parameter int         HALF_9600   = mlcs_pkg::CLK_HZ / (2 * mlcs_pkg::BAUD_9600)
) (
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	input  wire logic [mlcs_pkg::ADDR_W-1:0]   addr_i,
	input  wire logic [mlcs_pkg::DATA_W-1:0]   wdata_i,
	input  wire logic                          wr_i,
	input  wire logic                          rd_i,
	output logic      [mlcs_pkg::DATA_W-1:0]   rdata_o,
	input  wire logic [mlcs_pkg::LINES-1:0]    line_is_sync_i,
	input  wire logic [mlcs_pkg::LINES-1:0]    set_ready_i,
	input  wire logic [mlcs_pkg::LINES-1:0]    aux_receive_i,
	input  wire logic [mlcs_pkg::LINES-1:0]    clear_to_send_i,
	input  wire logic [mlcs_pkg::LINES-1:0]    carrier_detect_state_i,
	input  wire logic [mlcs_pkg::LINES-1:0]    ring_i,
	output logic      [mlcs_pkg::LINES-1:0]    term_ready_o,
	output logic      [mlcs_pkg::LINES-1:0]    transmit_request_out_o,
	output logic      [mlcs_pkg::LINES-1:0]    new_sync_o,
	output logic      [mlcs_pkg::LINES-1:0]    aux_send_o,
	input  wire logic [7:0]                    group_rate_sel_i,
	output logic      [3:0]                    int_bit_clk_o,
	output logic      [8:0]                    rx_vector_o,
	output logic      [8:0]                    tx_vector_o,
	output logic      [8:0]                    modem_vector_o
);
	import mlcs_pkg::*;

	// Older unit present pushes us up one slot
	localparam logic [17:0] UNIT_BASE =
		BASE_FIRST + 18'(SLOT_STRIDE * 18'(UNIT_SLOT + int'(OLDER_UNIT)));

	logic [3:0]        ctrl       [LINES];
	logic [3:0]        next_ctrl  [LINES];
	logic [3:0]        prev_stat  [LINES];
	logic [3:0]        next_prev  [LINES];
	logic [3:0]        lead_stat  [LINES];
	logic [3:0]        scan_stat  [LINES];
	logic [LINE_W-1:0] line;
	logic [LINE_W-1:0] next_line;
	logic [LINE_W-1:0] flush_idx;
	logic [LINE_W-1:0] next_flush_idx;
	logic              scan_en;
	logic              next_scan_en;
	logic              int_en;
	logic              next_int_en;
	logic              done;
	logic              next_done;
	logic              maint;
	logic              next_maint;
	logic              step_pend;
	logic              next_step_pend;
	logic [3:0]        flags;
	logic [3:0]        next_flags;
	mlcs_scan_type     state;
	mlcs_scan_type     next_state;
	logic [DATA_W-1:0] next_rdata;
	logic              csr_wr;
	logic              lsr_wr;
	logic              csr_rd;
	logic              lsr_rd;
	logic              sel_en;
	logic [3:0]        trans;
	logic              busy;
	logic              hw_done;
	logic              any_ctrl;

	function automatic logic hit(input logic [17:0] a, input logic [17:0] off);
		hit = (a == UNIT_BASE + off);
	endfunction
	assign csr_wr = wr_i && hit(addr_i, OFF_CSR);
	assign lsr_wr = wr_i && hit(addr_i, OFF_LSR);
	assign csr_rd = rd_i && hit(addr_i, OFF_CSR);
	assign lsr_rd = rd_i && hit(addr_i, OFF_LSR);
	assign rx_vector_o    = VECTOR_BASE;
	assign tx_vector_o    = VECTOR_BASE + VECTOR_STEP;
	assign modem_vector_o = VECTOR_BASE + VECTOR_STEP + VECTOR_STEP;
	genvar g;
	generate
		for (g = 0; g < LINES; g++) begin : g_line
			// Shared bit four: data set ready or secondary receive by line type
			assign lead_stat[g] = {ring_i[g], carrier_detect_state_i[g],
				clear_to_send_i[g],
				line_is_sync_i[g] ? set_ready_i[g] : aux_receive_i[g]};
			// Maintenance forces every scan input on
			assign scan_stat[g] = maint ? MAINT_STAT : lead_stat[g];
			assign term_ready_o[g]           = ctrl[g][LSR_TERM_RDY];
			assign transmit_request_out_o[g] = ctrl[g][LSR_TX_REQ];
			assign new_sync_o[g] = ctrl[g][LSR_NS_AUX] && line_is_sync_i[g];
			assign aux_send_o[g] = ctrl[g][LSR_NS_AUX] && !line_is_sync_i[g];
		end
		for (g = 0; g < 4; g++) begin : g_clk
			mlcs_bit_clock #(
				.HALF_1200 (HALF_1200),
				.HALF_2400 (HALF_2400),
				.HALF_4800 (HALF_4800),
				.HALF_9600 (HALF_9600)
			) u_bit_clock (
				.clk_i      (clk_i),
				.rst_i      (rst_i),
				.rate_sel_i (mlcs_baud_type'(group_rate_sel_i[2*g +: 2])),
				.bit_clk_o  (int_bit_clk_o[g])
			);
		end
	endgenerate

	assign sel_en = ctrl[line][LSR_LINE_EN];
	// Ring counts only off-to-on; the others count either way
	always_comb begin
		trans = STAT_RESET;
		if (sel_en) begin
			trans = scan_stat[line] ^ prev_stat[line];
			trans[3] = trans[3] && scan_stat[line][3];
		end
	end
	assign busy = (state != MLCS_IDLE) || (scan_en && !done) || step_pend;
	// Per-line control storage
	always_comb begin
		for (int i = 0; i < LINES; i++) begin
			next_ctrl[i] = ctrl[i];
		end
		if (csr_wr && wdata_i[CSR_CLR_MUX]) begin
			for (int i = 0; i < LINES; i++) begin
				next_ctrl[i] = CTRL_RESET;
			end
		end else if (lsr_wr) begin
			next_ctrl[line] = wdata_i[3:0];
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < LINES; i++) begin
				ctrl[i] <= CTRL_RESET;
			end
		end else begin
			ctrl <= next_ctrl;
		end
	end

	// Scanner
	always_comb begin
		next_prev      = prev_stat;
		next_line      = line;
		next_flush_idx = flush_idx;
		next_scan_en   = scan_en;
		next_int_en    = int_en;
		next_done      = done;
		next_maint     = maint;
		next_step_pend = step_pend;
		next_flags     = flags;
		next_state     = state;
		hw_done        = 1'b0;
		case (state)
			MLCS_IDLE: begin
				if (((scan_en && !done) || step_pend) && !csr_wr) begin
					next_line      = line + 4'h1;
					next_step_pend = 1'b0;
					next_state     = MLCS_TEST;
				end
			end
			MLCS_TEST: begin
				if (sel_en) begin
					next_prev[line] = scan_stat[line];
				end
				if (|trans) begin
					hw_done    = 1'b1;
					next_flags = trans;
				end
				next_state = MLCS_IDLE;
			end
			MLCS_FLUSH: begin
				next_prev[flush_idx] = STAT_RESET;
				next_flush_idx       = flush_idx + 4'h1;
				if (flush_idx == 4'(LINES - 1)) begin
					next_state = MLCS_IDLE;
				end
			end
			default: begin
				next_state = MLCS_IDLE;
			end
		endcase
		if (csr_wr && wdata_i[CSR_FLUSH]) begin
			next_line      = 4'h0;
			next_flush_idx = 4'h0;
			next_scan_en   = 1'b0;
			next_int_en    = 1'b0;
			next_done      = 1'b0;
			next_maint     = 1'b0;
			next_step_pend = 1'b0;
			next_flags     = STAT_RESET;
			next_state     = MLCS_FLUSH;
		end else begin
			if (csr_wr) begin
				// Line only moves while the scanner rests
				if (state == MLCS_IDLE) begin
					next_line = wdata_i[CSR_LINE_LSB +: LINE_W];
				end
				next_scan_en = wdata_i[CSR_SCAN_EN];
				next_int_en  = wdata_i[CSR_INT_EN];
				next_done    = wdata_i[CSR_DONE];
				next_maint   = wdata_i[CSR_MAINT];
				if (wdata_i[CSR_STEP]) begin
					next_step_pend = 1'b1;
				end
			end
			// Detection beats a software clear in the same cycle
			if (hw_done) begin
				next_done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < LINES; i++) begin
				prev_stat[i] <= STAT_RESET;
			end
			line      <= 4'h0;
			flush_idx <= 4'h0;
			scan_en   <= 1'b0;
			int_en    <= 1'b0;
			done      <= 1'b0;
			maint     <= 1'b0;
			step_pend <= 1'b0;
			flags     <= STAT_RESET;
			state     <= MLCS_IDLE;
		end else begin
			prev_stat <= next_prev;
			line      <= next_line;
			flush_idx <= next_flush_idx;
			scan_en   <= next_scan_en;
			int_en    <= next_int_en;
			done      <= next_done;
			maint     <= next_maint;
			step_pend <= next_step_pend;
			flags     <= next_flags;
			state     <= next_state;
		end
	end

	// Read port; write-ones-only bits read zero
	always_comb begin
		next_rdata = '0;
		if (csr_rd) begin
			next_rdata = {flags, 2'b00, maint, 1'b0, done, int_en, scan_en, busy, line};
		end else if (lsr_rd) begin
			next_rdata = {8'h00, sel_en ? lead_stat[line] : STAT_RESET, ctrl[line]};
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= '0;
		end else begin
			rdata_o <= next_rdata;
		end
	end

	always_comb begin
		any_ctrl = 1'b0;
		for (int i = 0; i < LINES; i++) begin
			any_ctrl = any_ctrl | (|ctrl[i]);
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_lsr_look;
		lsr_rd && sel_en;
	endsequence
	sequence s_step_req;
		csr_wr && wdata_i[CSR_STEP] && !wdata_i[CSR_FLUSH] && state == MLCS_IDLE && !step_pend;
	endsequence

	a_all_line_control_reset_all: assert property (csr_wr && wdata_i[CSR_CLR_MUX] |=> !any_ctrl)
		else $error("all-line clear left a control bit set");
	a_gate_inhibit: assert property (lsr_rd && !sel_en |=> rdata_o[7:4] == 4'h0)
		else $error("status bits not inhibited");
	a_ring_read: assert property (s_lsr_look and ring_i[line] |=> rdata_o[7])
		else $error("ring not shown");
	a_ready_sync: assert property (s_lsr_look
		and line_is_sync_i[line] && set_ready_i[line] |=> rdata_o[4])
		else $error("data set ready not shown");
	a_aux_receive: assert property (s_lsr_look
		and !line_is_sync_i[line] && !aux_receive_i[line] |=> !rdata_o[4])
		else $error("secondary receive wrong");
	a_cts_read: assert property (s_lsr_look and clear_to_send_i[line] |=> rdata_o[5])
		else $error("clear to send not shown");
	a_carrier_off: assert property (s_lsr_look
		and !carrier_detect_state_i[line] |=> !rdata_o[6])
		else $error("carrier shown while off");
	a_term_ready: assert property (lsr_wr && wdata_i[LSR_TERM_RDY]
		|=> term_ready_o[$past(line)])
		else $error("terminal ready lead not driven");
	a_tx_request: assert property (lsr_wr && !wdata_i[LSR_TX_REQ]
		|=> !transmit_request_out_o[$past(line)])
		else $error("request to send lead stuck");
	a_step_advance: assert property (s_step_req
		|-> ##2 line == $past(wdata_i[3:0], 2) + 4'h1)
		else $error("step did not advance one line");
	a_flush_busy: assert property (csr_wr && wdata_i[CSR_FLUSH]
		|=> (busy && line == 4'h0)[*8])
		else $error("flush not busy");

endmodule

//--- tb/mlcs_modem_model.sv
// Behavioural modems on all sixteen lines.
// Assumes the bench supplies a static lead pattern per line.
`timescale 1ns/1ps
module mlcs_modem_model (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [15:0] term_ready_i,
	input  wire logic [15:0] transmit_request_i,
	input  wire logic [15:0] pattern_i,
	output logic      [15:0] set_ready_o,
	output logic      [15:0] aux_receive_o,
	output logic      [15:0] clear_to_send_o,
	output logic      [15:0] carrier_o,
	output logic      [15:0] ring_o
);
	assign ring_o        = pattern_i;
	assign set_ready_o   = term_ready_i;
	assign carrier_o     = pattern_i & term_ready_i;
	assign aux_receive_o = ~pattern_i;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			clear_to_send_o <= 16'h0000;
		end else begin
			// Lags a cycle, so the bench must not read too early
			clear_to_send_o <= transmit_request_i;
		end
	end
endmodule

//--- tb/mlcs_modem_ctrl_tb.sv
// Self-checking bench for the modem control and status bank.
// Assumes the bank sits at the first slot with no older unit.
`timescale 1ns/1ps
module mlcs_modem_ctrl_tb;
	import mlcs_pkg::*;
	localparam logic [17:0] CSR_A = BASE_FIRST + OFF_CSR;
	localparam logic [17:0] LSR_A = BASE_FIRST + OFF_LSR;
	localparam logic [15:0] PAT   = 16'hA5A5;
	localparam logic [15:0] SYNC  = 16'h0F0F;
	localparam int          HALF [4] = '{8, 4, 2, 1};
	// High nibble line, low nibble control bits
	localparam logic [7:0]  ROWS [6] = '{8'h0F, 8'h3F, 8'h5E, 8'h8B, 8'hCD, 8'hF3};
	localparam logic [15:0] SCAN_CSR = {PAT[3], PAT[3], 2'b11, 4'h0, 1'b1, 3'h0, 4'h3};
	logic        clk_i   = 1'b0;
	logic        rst_i   = 1'b1;
	logic [17:0] addr_i  = 18'h00000;
	logic [15:0] wdata_i = 16'h0000;
	logic        wr_i    = 1'b0;
	logic        rd_i    = 1'b0;
	logic [15:0] rdata_o, set_ready, aux_receive, cts, carrier, ring, rd_val;
	logic [15:0] term_ready_o, transmit_request_out_o, new_sync_o, aux_send_o;
	logic [3:0]  int_bit_clk_o;
	logic [8:0]  rx_vector_o, tx_vector_o, modem_vector_o;
	int          num_errors = 0;
	int          cmp_count  = 0;
	always #5 clk_i = ~clk_i;
	mlcs_modem_ctrl #(.HALF_1200(8), .HALF_2400(4), .HALF_4800(2), .HALF_9600(1)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .line_is_sync_i(SYNC),
		.set_ready_i(set_ready), .aux_receive_i(aux_receive), .clear_to_send_i(cts),
		.carrier_detect_state_i(carrier), .ring_i(ring), .term_ready_o(term_ready_o),
		.transmit_request_out_o(transmit_request_out_o), .new_sync_o(new_sync_o),
		.aux_send_o(aux_send_o), .group_rate_sel_i(8'hE4), .int_bit_clk_o(int_bit_clk_o),
		.rx_vector_o(rx_vector_o), .tx_vector_o(tx_vector_o), .modem_vector_o(modem_vector_o));
	mlcs_modem_model modems (
		.clk_i(clk_i), .rst_i(rst_i), .term_ready_i(term_ready_o),
		.transmit_request_i(transmit_request_out_o), .pattern_i(PAT),
		.set_ready_o(set_ready), .aux_receive_o(aux_receive), .clear_to_send_o(cts),
		.carrier_o(carrier), .ring_o(ring));
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic time_out(input string what);
		num_errors++;
		$display("BAD wait %s expected done seen timeout", what);
		final_report();
	endtask
	task automatic chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_lead(input string n, input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s expected %b seen %b", n, e, g);
		end
	endtask
	task automatic bus_wr(input logic [17:0] a, input logic [15:0] d);
		@(posedge clk_i);
		wr_i    <= 1'b1;
		addr_i  <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic bus_rd(input logic [17:0] a);
		@(posedge clk_i);
		rd_i   <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		rd_val = rdata_o;
	endtask
	task automatic wait_csr(input int b, input logic v);
		int n;
		for (n = 0; n < 40; n++) begin
			repeat (4) @(posedge clk_i); // Spaced polls
			bus_rd(CSR_A);
			if (rd_val[b] === v) break;
		end
		if (n == 40) time_out("csr");
	endtask
	task automatic wait_lvl(input int g, input logic v, output int n);
		for (n = 0; n < 100; n++) begin
			@(posedge clk_i);
			#1;
			if (int_bit_clk_o[g] === v) break;
		end
		if (n == 100) time_out("bit clock");
	endtask
	function automatic logic [15:0] exp_lsr(input int l, input logic [3:0] c);
		logic p;
		logic dsr;
		p       = PAT[l];
		dsr     = SYNC[l] ? c[1] : ~p;
		exp_lsr = {8'h00, (c[0] ? {p, p & c[1], c[2], dsr} : 4'h0), c};
	endfunction
	initial begin
		int         l;
		int         a;
		int         b;
		logic [3:0] c;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		bus_rd(LSR_A);
		chk_word("lsr after reset", 16'h0000, rd_val);
		chk_word("term ready after reset", 16'h0000, term_ready_o);
		chk_word("rts after reset", 16'h0000, transmit_request_out_o);
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			l = ROWS[i][7:4];
			c = ROWS[i][3:0];
			bus_wr(CSR_A, {12'h000, 4'(l)});
			bus_wr(LSR_A, {12'h000, c});
			repeat (2) @(posedge clk_i);
			bus_rd(LSR_A);
			chk_word("lsr", exp_lsr(l, c), rd_val);
			chk_lead("term ready", c[1], term_ready_o[l]);
			chk_lead("rts", c[2], transmit_request_out_o[l]);
			chk_lead("new sync", c[3] & SYNC[l], new_sync_o[l]);
			chk_lead("aux send", c[3] & ~SYNC[l], aux_send_o[l]);
		end
		for (int i = 0; i < 6; i++) begin
			l = ROWS[i][7:4];
			bus_wr(CSR_A, {12'h000, 4'(l)});
			bus_rd(LSR_A);
			chk_word("lsr kept", exp_lsr(l, ROWS[i][3:0]), rd_val);
		end
		$display("test line table done");
		bus_wr(CSR_A, 16'h0102);
		repeat (4) @(posedge clk_i);
		bus_rd(CSR_A);
		chk_word("csr after step", SCAN_CSR, rd_val);
		@(posedge clk_i);
		#1;
		chk_word("rdata after read", 16'h0000, rdata_o);
		bus_wr(CSR_A, 16'h0800);
		wait_csr(CSR_BUSY, 1'b0); // Flush must finish first
		chk_word("csr after flush", 16'h0000, rd_val);
		bus_wr(CSR_A, 16'h0020);
		wait_csr(CSR_DONE, 1'b1);
		chk_word("csr free scan", SCAN_CSR | 16'h0020, rd_val & 16'hF0AF);
		$display("test scan done");
		bus_wr(CSR_A, 16'h0400);
		#1;
		chk_word("term ready cleared", 16'h0000, term_ready_o);
		chk_word("rts cleared", 16'h0000, transmit_request_out_o);
		chk_word("aux send cleared", 16'h0000, aux_send_o | new_sync_o);
		bus_wr(CSR_A, 16'h000F);
		bus_rd(LSR_A);
		chk_word("lsr cleared", 16'h0000, rd_val);
		$display("test all-line clear done");
		bus_wr(LSR_A, 16'h0003);
		bus_wr(CSR_A, 16'h034E);
		repeat (4) @(posedge clk_i);
		bus_rd(CSR_A);
		chk_word("csr maint step", 16'hF2CF, rd_val);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		bus_rd(CSR_A);
		chk_word("csr after mid reset", 16'h0000, rd_val);
		chk_word("term ready after mid reset", 16'h0000, term_ready_o);
		$display("test maint and reset done");
		bus_wr(BASE_FIRST + 18'h00014, 16'hFFFF);
		bus_rd(BASE_FIRST + 18'h00014);
		chk_word("unmapped", 16'h0000, rd_val);
		bus_rd(BASE_FIRST + SLOT_STRIDE + OFF_LSR);
		chk_word("next slot", 16'h0000, rd_val);
		bus_rd(LSR_A);
		chk_word("lsr untouched", 16'h0000, rd_val);
		$display("test decode done");
		for (int g = 0; g < 4; g++) begin
			wait_lvl(g, 1'b0, a);
			wait_lvl(g, 1'b1, a);
			wait_lvl(g, 1'b0, a);
			wait_lvl(g, 1'b1, b);
			chk_word("bit clock period", 16'(2 * HALF[g]), 16'(a + b + 2));
		end
		$display("test bit clocks done");
		chk_word("rx vector", {7'h00, VECTOR_FIRST}, {7'h00, rx_vector_o});
		chk_word("tx vector", {7'h00, VECTOR_FIRST + 9'h004}, {7'h00, tx_vector_o});
		chk_word("modem vector", {7'h00, VECTOR_FIRST + 9'h008}, {7'h00, modem_vector_o});
		$display("test vectors done");
		final_report();
	end
endmodule
